// ### include/tpd_pkg.sv
// constants and types shared by the trace pixel detector design
`default_nettype none
package tpd_pkg;
  localparam int TPD_PIXELS     = 711;  // trace positions per sweep
  localparam int TPD_IDXW       = 10;   // width of a pixel index
  localparam int TPD_FRAC       = 8;    // fraction bits of the video filter
  localparam int TPD_FIFO_DEPTH = 32;   // result buffer words
  localparam logic [TPD_IDXW-1:0] TPD_IDX_LAST  = 10'h2c6;  // index 710
  localparam logic [TPD_IDXW-1:0] TPD_IDX_RESET = 10'h000;  // first pixel

  // detector selection
  typedef enum logic [1:0] {
    MODE_MAX    = 2'h0,
    MODE_SAMPLE = 2'h1,
    MODE_RMS    = 2'h2,
    MODE_MAXMIN = 2'h3
  } tpd_mode_t;

  // group engine states, one-hot
  typedef enum logic [3:0] {
    ST_ACC  = 4'h1,
    ST_DIV  = 4'h2,
    ST_SQRT = 4'h4,
    ST_PUSH = 4'h8
  } tpd_state_t;
endpackage : tpd_pkg
`default_nettype wire

// ### rtl/tpd_fifo.sv
// result buffer with registered ready and registered output stage
`timescale 1ns/1ps
`default_nettype none
module tpd_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 32
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // filling side
  input  wire logic         in_valid,
  output var  logic         in_ready,
  input  wire logic [W-1:0] in_data,
  // draining side
  output var  logic         out_valid,
  input  wire logic         out_ready,
  output var  logic [W-1:0] out_data
);
  localparam int PW = $clog2(DEPTH);

  // depth must be a power of two so the pointers wrap on their own
  if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
    $error("tpd_fifo: DEPTH must be a power of two, at least 2");
  end

  logic [W-1:0]  mem [DEPTH];   // storage words
  logic [PW-1:0] wr_ptr;        // next slot to write
  logic [PW-1:0] rd_ptr;        // next slot to read
  logic [PW:0]   count;         // words held in storage
  logic [PW-1:0] next_wr_ptr;
  logic [PW-1:0] next_rd_ptr;
  logic [PW:0]   next_count;
  logic          next_in_ready;
  logic          next_out_valid;
  logic [W-1:0]  next_out_data;
  logic          push;
  logic          load;

  // pointer and output stage update
  always_comb begin
    push           = in_valid && in_ready;
    load           = (count != '0) && (!out_valid || out_ready);
    next_wr_ptr    = push ? wr_ptr + 1'b1 : wr_ptr;
    next_rd_ptr    = load ? rd_ptr + 1'b1 : rd_ptr;
    next_count     = count + {{PW{1'b0}}, push} - {{PW{1'b0}}, load};
    // ready is registered, so it looks at the count one cycle ahead
    next_in_ready  = next_count < (PW+1)'(DEPTH);
    next_out_valid = out_valid && !out_ready;
    next_out_data  = out_data;
    if (load) begin
      next_out_valid = 1'b1;
      next_out_data  = mem[rd_ptr];
    end
  end

  // state registers; storage words need no reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr    <= '0;
      rd_ptr    <= '0;
      count     <= '0;
      in_ready  <= 1'b1;
      out_valid <= 1'b0;
      out_data  <= '0;
    end else begin
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      count     <= next_count;
      in_ready  <= next_in_ready;
      out_valid <= next_out_valid;
      out_data  <= next_out_data;
    end
  end

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end
endmodule : tpd_fifo
`default_nettype wire

// ### rtl/tpd_trace_pixel_detector.sv
// video filter and pixel detector that build a 711-point display trace
`timescale 1ns/1ps
`default_nettype none
module tpd_trace_pixel_detector #(
  parameter int DW         = 16,
  parameter int NW         = 16,
  parameter int SHW        = 4,
  parameter int FIFO_DEPTH = tpd_pkg::TPD_FIFO_DEPTH
) (
  // clock and reset
  input  wire logic                          clk,
  input  wire logic                          rst_n,
  // envelope sample stream
  input  wire logic                          in_valid,
  input  wire logic [DW-1:0]                 in_data,
  output var  logic                          in_ready,
  // configuration
  input  wire logic [SHW-1:0]                vid_shift,
  input  wire tpd_pkg::tpd_mode_t            det_mode,
  input  wire logic [NW-1:0]                 samples_per_pixel,
  // pixel result stream
  output var  logic                          pix_valid,
  input  wire logic                          pix_ready,
  output var  logic [DW-1:0]                 pix_value,
  output var  logic [DW-1:0]                 pix_min,
  output var  logic [tpd_pkg::TPD_IDXW-1:0]  pix_index,
  output var  logic                          pix_last
);
  import tpd_pkg::*;

  localparam int ACCW = DW + TPD_FRAC;          // filter state width
  localparam int SW   = 2 * DW + NW;            // sum of squares width
  localparam int STW  = $clog2(SW + 1);         // iteration counter width
  localparam int RW   = 1 + TPD_IDXW + 2 * DW;  // buffered result width

  if (DW < 2 || NW < 1 || SHW < 1 || SHW > 6) begin : g_bad_param
    $error("tpd_trace_pixel_detector: unsupported width parameter");
  end
  // a zero group size would never close a pixel, so treat it as one
  function automatic logic [NW-1:0] group_len(input logic [NW-1:0] n);
    return (n == '0) ? NW'(1) : n;
  endfunction : group_len

  tpd_state_t              state;      // group engine state
  tpd_mode_t               mode_q;     // mode held for the whole group
  logic [NW-1:0]           n_q;        // group size held for the group
  logic [NW-1:0]           grp_cnt;    // samples taken in this group
  logic [DW-1:0]           grp_max;    // running largest value
  logic [DW-1:0]           grp_min;    // running smallest value
  logic [DW-1:0]           grp_first;  // first value of the group
  logic [SW-1:0]           sumsq;      // running sum of squares
  logic [ACCW-1:0]         filt_acc;   // video filter state
  logic [TPD_IDXW-1:0]     pix_idx;    // pixel being built
  logic [NW:0]             dv_rem;     // divider remainder
  logic [SW-1:0]           dv_q;       // dividend shifting into quotient
  logic [STW-1:0]          steps;      // divider and root iterations
  logic [2*DW-1:0]         sq_rad;     // radicand, shifted two bits a step
  logic [DW+1:0]           sq_rem;     // root remainder
  logic [DW-1:0]           sq_root;    // root being built
  logic [DW-1:0]           res_val, res_min; // result waiting for buffer
  logic [TPD_IDXW-1:0]     res_idx;
  logic                    res_last;
  logic                    res_valid;
  logic                    fifo_ready; // buffer can take a result
  // next values, one per register above
  tpd_state_t              next_state;
  tpd_mode_t               next_mode_q;
  logic [NW-1:0]           next_n_q, next_grp_cnt;
  logic [DW-1:0]           next_grp_max, next_grp_min, next_grp_first;
  logic [SW-1:0]           next_sumsq, next_dv_q;
  logic [ACCW-1:0]         next_filt_acc;
  logic [TPD_IDXW-1:0]     next_pix_idx, next_res_idx;
  logic [NW:0]             next_dv_rem;
  logic [STW-1:0]          next_steps;
  logic [2*DW-1:0]         next_sq_rad;
  logic [DW+1:0]           next_sq_rem;
  logic [DW-1:0]           next_sq_root, next_res_val, next_res_min;
  logic                    next_res_last, next_res_valid, next_in_ready;
  logic                    take;       // sample accepted this cycle
  logic                    first;      // sample opens a new group
  logic                    grp_end;    // sample closes the group
  logic signed [ACCW+1:0]  diff, fsum; // filter error term and sum
  logic [DW-1:0]           new_y;      // filtered sample
  logic [2*DW-1:0]         sq;         // square of filtered sample
  logic [NW:0]             dv_trial;   // shifted divider remainder
  logic [DW+2:0]           sq_trial, sq_test; // root trial and test
  // filter, detector and result engine
  always_comb begin
    next_state     = state;
    next_mode_q    = mode_q;
    next_n_q       = n_q;
    next_grp_cnt   = grp_cnt;
    next_grp_max   = grp_max;
    next_grp_min   = grp_min;
    next_grp_first = grp_first;
    next_sumsq     = sumsq;
    next_filt_acc  = filt_acc;
    next_pix_idx   = pix_idx;
    next_dv_rem    = dv_rem;
    next_dv_q      = dv_q;
    next_steps     = steps;
    next_sq_rad    = sq_rad;
    next_sq_rem    = sq_rem;
    next_sq_root   = sq_root;
    next_res_val   = res_val;
    next_res_min   = res_min;
    next_res_idx   = res_idx;
    next_res_last  = res_last;
    next_res_valid = res_valid;
    // unsigned amplitude in, no phase carried
    take  = in_valid && in_ready;
    first = (grp_cnt == '0);
    // first-order lowpass, cutoff falls as vid_shift rises
    diff  = $signed({2'b00, in_data, {TPD_FRAC{1'b0}}})
          - $signed({2'b00, filt_acc});
    fsum  = $signed({2'b00, filt_acc}) + (diff >>> vid_shift);
    new_y = fsum[ACCW-1:TPD_FRAC];
    sq    = (2*DW)'(new_y) * (2*DW)'(new_y);
    grp_end  = (grp_cnt == (first ? group_len(samples_per_pixel) : n_q)
                - NW'(1));
    dv_trial = {dv_rem[NW-1:0], dv_q[SW-1]};
    // remainder never exceeds twice the root, so DW+1 bits carry it
    sq_test  = {sq_rem[DW:0], sq_rad[2*DW-1:2*DW-2]};
    sq_trial = {1'b0, sq_root, 2'b01};
    case (state)
      ST_ACC: begin
        if (take) begin
          next_filt_acc = fsum[ACCW-1:0];
          // contiguous groups of n samples
          next_grp_cnt  = grp_end ? '0 : grp_cnt + NW'(1);
          if (first) begin
            // group settings freeze at its first sample
            next_mode_q    = det_mode;
            next_n_q       = group_len(samples_per_pixel);
            next_grp_max   = new_y;
            next_grp_min   = new_y;
            next_grp_first = new_y;
            next_sumsq     = SW'(sq);
          end else begin
            if (new_y > grp_max) next_grp_max = new_y;
            if (new_y < grp_min) next_grp_min = new_y;
            next_sumsq = sumsq + SW'(sq);
          end
          if (grp_end) begin
            // reduce the group to one pixel result
            next_res_idx  = pix_idx;
            next_res_last = (pix_idx == TPD_IDX_LAST);
            next_res_min  = next_grp_min;
            next_steps    = '0;
            case (first ? det_mode : mode_q)
              MODE_SAMPLE: next_res_val = next_grp_first;
              MODE_RMS:    next_res_val = '0;
              default:     next_res_val = next_grp_max;
            endcase
            if ((first ? det_mode : mode_q) == MODE_RMS) begin
              // mean of squares first, then its root
              next_dv_rem = '0;
              next_dv_q   = next_sumsq;
              next_state  = ST_DIV;
            end else begin
              next_res_valid = 1'b1;
              next_state     = ST_PUSH;
            end
          end
        end
      end
      ST_DIV: begin
        // restoring divide, one quotient bit a cycle
        next_dv_rem = dv_trial;
        next_dv_q   = {dv_q[SW-2:0], 1'b0};
        if (dv_trial >= {1'b0, n_q}) begin
          next_dv_rem = dv_trial - {1'b0, n_q};
          next_dv_q   = {dv_q[SW-2:0], 1'b1};
        end
        next_steps = steps + STW'(1);
        if (steps == STW'(SW - 1)) begin
          next_steps   = '0;
          next_sq_rad  = next_dv_q[2*DW-1:0];
          next_sq_rem  = '0;
          next_sq_root = '0;
          next_state   = ST_SQRT;
        end
      end
      ST_SQRT: begin
        // digit-by-digit integer square root
        next_sq_rad  = {sq_rad[2*DW-3:0], 2'b00};
        next_sq_rem  = sq_test[DW+1:0];
        next_sq_root = {sq_root[DW-2:0], 1'b0};
        if (sq_test >= sq_trial) begin
          next_sq_rem  = (DW+2)'(sq_test - sq_trial);
          next_sq_root = {sq_root[DW-2:0], 1'b1};
        end
        next_steps = steps + STW'(1);
        if (steps == STW'(DW - 1)) begin
          next_res_val   = next_sq_root;
          next_res_valid = 1'b1;
          next_state     = ST_PUSH;
        end
      end
      ST_PUSH: begin
        // hold the result until the buffer takes it
        if (res_valid && fifo_ready) begin
          next_res_valid = 1'b0;
          // 711 positions per sweep, then wrap
          next_pix_idx = (pix_idx == TPD_IDX_LAST) ? TPD_IDX_RESET
                                                   : pix_idx + 1'b1;
          next_state   = ST_ACC;
        end
      end
      default: next_state = ST_ACC;
    endcase
    // samples stall while a result is worked out or waits
    next_in_ready = (next_state == ST_ACC);
  end
  // engine registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_ACC;      mode_q <= MODE_MAX;    n_q <= NW'(1);
      grp_cnt <= '0;        grp_max <= '0;         grp_min <= '0;
      grp_first <= '0;      sumsq <= '0;           filt_acc <= '0;
      pix_idx <= TPD_IDX_RESET;                    dv_rem <= '0;
      dv_q <= '0;           steps <= '0;           sq_rad <= '0;
      sq_rem <= '0;         sq_root <= '0;         res_val <= '0;
      res_min <= '0;        res_idx <= '0;         res_last <= 1'b0;
      res_valid <= 1'b0;    in_ready <= 1'b1;
    end else begin
      state <= next_state;  mode_q <= next_mode_q; n_q <= next_n_q;
      grp_cnt <= next_grp_cnt;      grp_max <= next_grp_max;
      grp_min <= next_grp_min;      grp_first <= next_grp_first;
      sumsq <= next_sumsq;          filt_acc <= next_filt_acc;
      pix_idx <= next_pix_idx;      dv_rem <= next_dv_rem;
      dv_q <= next_dv_q;            steps <= next_steps;
      sq_rad <= next_sq_rad;        sq_rem <= next_sq_rem;
      sq_root <= next_sq_root;      res_val <= next_res_val;
      res_min <= next_res_min;      res_idx <= next_res_idx;
      res_last <= next_res_last;    res_valid <= next_res_valid;
      in_ready <= next_in_ready;
    end
  end
  // result buffer; its outputs are flops and feed the pixel port
  logic [RW-1:0] fifo_out;
  tpd_fifo #(.W(RW), .DEPTH(FIFO_DEPTH)) tpd_fifo_inst (
    .clk      (clk),
    .rst_n    (rst_n),
    .in_valid (res_valid),
    .in_ready (fifo_ready),
    .in_data  ({res_last, res_idx, res_min, res_val}),
    .out_valid(pix_valid),
    .out_ready(pix_ready),
    .out_data (fifo_out)
  );
  assign {pix_last, pix_index, pix_min, pix_value} = fifo_out;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  filt_bypass_a: assert property (take && vid_shift == '0 |=>
    filt_acc[ACCW-1:TPD_FRAC] == $past(in_data))
    else $error("unfiltered sample not passed through");
  stall_ready_a: assert property (state != ST_ACC |-> !in_ready)
    else $error("sample accepted while engine busy");
  pix_range_a: assert property (pix_idx <= TPD_IDX_LAST)
    else $error("pixel index beyond trace end");
  pix_wrap_a: assert property (state == ST_PUSH && fifo_ready &&
    pix_idx == TPD_IDX_LAST |=> pix_idx == TPD_IDX_RESET)
    else $error("trace did not wrap after last pixel");
  max_track_a: assert property (take && !first |=>
    grp_max >= $past(new_y) && grp_max >= $past(grp_max))
    else $error("running maximum lost a value");
  maxmin_order_a: assert property (res_valid &&
    mode_q == MODE_MAXMIN |-> res_val >= res_min)
    else $error("maximum below minimum");
  rms_bound_a: assert property (res_valid && mode_q == MODE_RMS
    |-> res_val <= grp_max && res_val >= grp_min)
    else $error("rms outside group range");
  rms_time_a: assert property (state == ST_DIV && steps == '0
    |-> ##(SW + DW) res_valid)
    else $error("rms result late");
  sample_hold_a: assert property (take && !first |=>
    grp_first == $past(grp_first))
    else $error("sample value overwritten");
  group_len_a: assert property (state == ST_ACC && !first
    |-> grp_cnt < n_q)
    else $error("group longer than set");
  cov_max_c:    cover property (res_valid && mode_q == MODE_MAX);
  cov_sample_c: cover property (res_valid && mode_q == MODE_SAMPLE);
  cov_rms_c:    cover property (res_valid && mode_q == MODE_RMS);
  cov_wrap_c:   cover property (pix_valid && pix_last && pix_ready);
  cov_full_c:   cover property (res_valid && !fifo_ready);
endmodule : tpd_trace_pixel_detector
`default_nettype wire

// ### verification/tpd_partner.sv
// envelope source and trace sink that surround the pixel detector
`timescale 1ns/1ps
`default_nettype none
module tpd_partner
  import tpd_pkg::*;
(
  // clock and reset
  input  wire logic                 clk,
  input  wire logic                 rst_n,
  // sample side
  output var  logic                 in_valid,
  output var  logic [15:0]          in_data,
  input  wire logic                 in_ready,
  // pixel side
  input  wire logic                 pix_valid,
  output var  logic                 pix_ready,
  input  wire logic [15:0]          pix_value,
  input  wire logic [15:0]          pix_min,
  input  wire logic [TPD_IDXW-1:0]  pix_index,
  input  wire logic                 pix_last
);
  logic [15:0] src_q[$];  // amplitudes waiting to go out
  logic [42:0] snk_q[$];  // value, min, index, last as taken
  logic        hold_off;  // sink refuses every result
  logic        slow;      // sink takes every other cycle
  initial begin
    hold_off = 1'b0;
    slow = 1'b0;
  end
  // source: magnitudes only, held until taken
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      in_valid <= 1'b0;
      in_data  <= 16'h0;
    end else begin
      if (in_valid && in_ready) void'(src_q.pop_front());
      if (src_q.size() > 0) begin
        in_valid <= 1'b1;
        in_data  <= src_q[0];
      end else begin
        // idle data wanders so a stale value is never mistaken for a sample
        in_valid <= 1'b0;
        in_data  <= ~in_data;
      end
    end
  end
  // sink: records what it accepts, can stall or throttle
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pix_ready <= 1'b0;
    end else begin
      if (pix_valid && pix_ready)
        snk_q.push_back({pix_value, pix_min, pix_index, pix_last});
      pix_ready <= !hold_off && !(slow && pix_ready);
    end
  end
endmodule : tpd_partner
`default_nettype wire

// ### verification/tpd_trace_pixel_detector_bench.sv
// self-checking bench for the trace pixel detector
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  error_cnt++; $display("unexpected %s exp %0h got %0h", nm, ex, got); \
  end end
module tpd_trace_pixel_detector_bench;
  import tpd_pkg::*;
  logic                clk;       // 100 MHz
  logic                rst_n;     // async, active low
  logic                in_valid;  // from source model
  logic                in_ready;
  logic [15:0]         in_data;
  logic [3:0]          vid_shift;
  tpd_mode_t           det_mode;
  logic [15:0]         samples_per_pixel;
  logic                pix_valid;
  logic                pix_ready;  // from sink model
  logic [15:0]         pix_value;
  logic [15:0]         pix_min;
  logic [TPD_IDXW-1:0] pix_index;
  logic                pix_last;
  logic [TPD_IDXW-1:0] exp_idx;   // next expected trace position
  int                  error_cnt;
  int                  checks_done;
  int                  cyc;       // cycle count for the hang guard
  int                  lasts;     // end-of-sweep flags seen

  tpd_trace_pixel_detector tpd_trace_pixel_detector_inst (
    .clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .vid_shift(vid_shift), .det_mode(det_mode),
    .samples_per_pixel(samples_per_pixel), .pix_valid(pix_valid),
    .pix_ready(pix_ready), .pix_value(pix_value), .pix_min(pix_min),
    .pix_index(pix_index), .pix_last(pix_last));
  tpd_partner tpd_partner_inst (
    .clk(clk), .rst_n(rst_n), .in_valid(in_valid), .in_data(in_data),
    .in_ready(in_ready), .pix_valid(pix_valid), .pix_ready(pix_ready),
    .pix_value(pix_value), .pix_min(pix_min), .pix_index(pix_index),
    .pix_last(pix_last));

  // clock
  initial clk = 1'b0;
  always #5 clk = ~clk;
  // hang guard: whole run is well under this
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      error_cnt++;
      end_of_test();
    end
  end

  // configuration changes only while the engine is idle
  task automatic setup(input tpd_mode_t m, input logic [15:0] n,
                       input logic [3:0] s);
    @(posedge clk);
    det_mode          <= m;
    samples_per_pixel <= n;
    vid_shift         <= s;
    @(posedge clk);
  endtask : setup

  task automatic feed(input logic [15:0] v);
    tpd_partner_inst.src_q.push_back(v);
  endtask : feed

  // waits for one result and judges it against the running index
  task automatic expect_pix(input logic [15:0] v, input logic [15:0] mn,
                            input bit chk_min);
    logic [42:0] r;
    int          w;
    w = 0;
    while (tpd_partner_inst.snk_q.size() == 0 && w < 3000) begin
      @(posedge clk);
      w++;
    end
    if (w >= 3000) begin
      error_cnt++;
      $display("unexpected result_count exp 1 got 0");
      return;
    end
    r = tpd_partner_inst.snk_q.pop_front();
    `CHK("pix_value", v, r[42:27])
    if (chk_min) `CHK("pix_min", mn, r[26:11])
    `CHK("pix_index", exp_idx, r[10:1])
    `CHK("pix_last", exp_idx == TPD_IDX_LAST, r[0])
    if (r[0] === 1'b1) lasts++;
    exp_idx = (exp_idx == TPD_IDX_LAST) ? TPD_IDX_RESET : exp_idx + 10'h1;
  endtask : expect_pix

  // extreme amplitudes, two groups back to back
  task automatic t_max();
    setup(MODE_MAX, 16'h4, 4'h0);
    feed(16'h3); feed(16'h9); feed(16'h2); feed(16'h7);
    feed(16'hffff); feed(16'h0); feed(16'h1); feed(16'h2);
    expect_pix(16'h9, 16'h2, 1'b1);
    expect_pix(16'hffff, 16'h0, 1'b1);
    $display("t_max done");
  endtask : t_max

  // one group run through every detector mode
  task automatic t_modes();
    tpd_mode_t   m[4];
    logic [15:0] ev[4];
    m  = '{MODE_MAX, MODE_SAMPLE, MODE_RMS, MODE_MAXMIN};
    ev = '{16'h14, 16'h5, 16'he, 16'h14}; // rms: sqrt(850/4) floors to 14
    for (int k = 0; k < 4; k++) begin
      setup(m[k], 16'h4, 4'h0);
      feed(16'h5); feed(16'h14); feed(16'h5); feed(16'h14);
      expect_pix(ev[k], 16'h5, m[k] == MODE_MAXMIN);
    end
    setup(MODE_RMS, 16'h2, 4'h0);
    feed(16'hffff); feed(16'hffff);
    expect_pix(16'hffff, 16'hffff, 1'b0);
    setup(MODE_SAMPLE, 16'h3, 4'h0);
    feed(16'h28); feed(16'h63); feed(16'h1);
    expect_pix(16'h28, 16'h1, 1'b0);
    // a zero group size closes every sample on its own
    setup(MODE_SAMPLE, 16'h0, 4'h0);
    feed(16'h33);
    expect_pix(16'h33, 16'h33, 1'b1);
    $display("t_modes done");
  endtask : t_modes

  // step from zero through a halving filter: 100 -> 50 -> 75
  task automatic t_filter();
    setup(MODE_SAMPLE, 16'h1, 4'h0);
    feed(16'h0);
    expect_pix(16'h0, 16'h0, 1'b0);
    setup(MODE_MAX, 16'h2, 4'h1);
    feed(16'h64); feed(16'h64);
    expect_pix(16'h4b, 16'h32, 1'b1);
    $display("t_filter done");
  endtask : t_filter

  // buffer fills against a stalled sink, then drains slowly in order
  task automatic t_fill();
    int left;  // samples the source still holds once stalled
    setup(MODE_SAMPLE, 16'h1, 4'h0);
    tpd_partner_inst.hold_off = 1'b1;
    for (int i = 0; i < 40; i++) feed(16'(i + 16'h100));
    repeat (300) @(posedge clk);
    #1;
    `CHK("in_ready", 1'b0, in_ready)
    // buffer words, its output stage and one held result are taken
    left = tpd_partner_inst.src_q.size();
    `CHK("src_left", 40 - TPD_FIFO_DEPTH - 2, left)
    tpd_partner_inst.hold_off = 1'b0;
    tpd_partner_inst.slow = 1'b1;
    for (int i = 0; i < 40; i++)
      expect_pix(16'(i + 16'h100), 16'h0, 1'b0);
    tpd_partner_inst.slow = 1'b0;
    $display("t_fill done");
  endtask : t_fill

  // a full sweep plus wrap: exactly one end flag per 711 pixels
  task automatic t_sweep();
    setup(MODE_SAMPLE, 16'h1, 4'h0);
    lasts = 0;
    for (int i = 0; i < TPD_PIXELS; i++) feed(16'(i * 3));
    for (int i = 0; i < TPD_PIXELS; i++)
      expect_pix(16'(i * 3), 16'h0, 1'b0);
    `CHK("last_count", 1, lasts)
    $display("t_sweep done");
  endtask : t_sweep

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : end_of_test

  // main sequence
  initial begin
    rst_n = 1'b0;
    det_mode = MODE_MAX;
    vid_shift = 4'h0;
    samples_per_pixel = 16'h1;
    exp_idx = TPD_IDX_RESET;
    error_cnt = 0;
    checks_done = 0;
    cyc = 0;
    lasts = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_max();
    t_modes();
    t_filter();
    t_fill();
    t_sweep();
    end_of_test();
  end
endmodule : tpd_trace_pixel_detector_bench
`default_nettype wire
